// [tb/ccpgt_peer_model.sv]
// ccpgt_peer_model: peer unit sources and pulse spacing monitor
`timescale 1ns/1ps
`default_nettype none
module ccpgt_peer_model
(
  // clock
  input  wire logic        sys_clk,
  // from the timer
  input  wire logic        sync_out,
  input  wire logic        compare_event_flag,
  // to the timer
  output logic [31:0]      sync_src,
  // measured spacing between the last two pulses
  output logic [15:0]      sync_gap,
  output logic [15:0]      cmp_gap
);
  logic [15:0] cyc_q;
  logic [15:0] sync_at_q;
  logic [15:0] cmp_at_q;

  initial
  begin
    sync_src  = 32'h0000_0000;
    sync_gap  = 16'h0000;
    cmp_gap   = 16'h0000;
    cyc_q     = 16'h0000;
    sync_at_q = 16'h0000;
    cmp_at_q  = 16'h0000;
  end

  // spacing is what peers rely on, so measure it instead of counting pulses
  always @(posedge sys_clk)
  begin
    cyc_q <= cyc_q + 16'h0001;
    if (sync_out === 1'b1)
    begin
      sync_gap  <= cyc_q - sync_at_q;
      sync_at_q <= cyc_q;
    end
    if (compare_event_flag === 1'b1)
    begin
      cmp_gap  <= cyc_q - cmp_at_q;
      cmp_at_q <= cyc_q;
    end
  end

  // a peer output held high two cycles, then dropped; a level, so no float
  task automatic pulse(input int idx);
    @(posedge sys_clk);
    sync_src[idx] <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sync_src[idx] <= 1'b0;
  endtask : pulse
endmodule : ccpgt_peer_model
`default_nettype wire

// [tb/testbench.sv]
// testbench: register level tests of the general purpose timer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ccpgt_pkg::*;
  logic        sys_clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] prdata;
  logic [31:0] sync_src;
  logic [7:1]  tb_tick;
  logic        sync_out;
  logic        compare_event_flag;
  logic        irq;
  logic [15:0] sync_gap;
  logic [15:0] cmp_gap;
  logic [31:0] q;
  logic        err;
  int          fail_count;
  int          samples_checked;
  int          cycles;

  ccpgt_timer dut (
    .sys_clk            (sys_clk),
    .rst_n              (rst_n),
    .psel               (psel),
    .penable            (penable),
    .pwrite             (pwrite),
    .paddr              (paddr),
    .pwdata             (pwdata),
    .pready             (pready),
    .pslverr            (pslverr),
    .prdata             (prdata),
    .tb_tick            (tb_tick),
    .sync_src           (sync_src),
    .sync_out           (sync_out),
    .compare_event_flag (compare_event_flag),
    .irq                (irq)
  );

  ccpgt_peer_model peer (
    .sys_clk            (sys_clk),
    .sync_out           (sync_out),
    .compare_event_flag (compare_event_flag),
    .sync_src           (sync_src),
    .sync_gap           (sync_gap),
    .cmp_gap            (cmp_gap)
  );

  always #5 sys_clk = ~sys_clk;

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report

  // a hang must still reach the verdict
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fail_count++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string what);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen,
               exp);
    end
  endtask : chk

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // no cycle limit here: only the bench timeout ends a stuck wait
    do
      @(posedge sys_clk);
    while (pready !== 1'b1);
    q   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so a following call never reassigns in this step
    @(posedge sys_clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : idle

  initial
  begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    tb_tick = 7'h00;
    fail_count = 0;
    samples_checked = 0;
    cycles = 0;
    idle(16);
    rst_n <= 1'b1;
    idle(1);
    // reset values and an unmapped place
    for (int a = 0; a < 10; a++)
    begin
      rd(8'(a * 4));
      chk(q, 32'h0000_0000, "reset value");
    end
    rd(8'h40);
    chk({31'h0, err}, 32'h0000_0001, "unmapped error");
    $display("test reset done");
    // dual mode: spacing of primary sync and secondary compare events
    wr(OFS_PRI_PRD, 32'h0000_0009);
    wr(OFS_SEC_PRD, 32'h0000_0004);
    wr(OFS_CTRL_LO, 32'h0000_8000);
    idle(60);
    chk({16'h0, sync_gap}, 32'h0000_000A, "primary gap");
    chk({16'h0, cmp_gap}, 32'h0000_0005, "compare gap");
    // interrupt: sticky status, mask, clear
    wr(OFS_CTRL_LO, 32'h0000_0000);
    idle(3);
    rd(OFS_IRQ_STS);
    chk(q & 32'h0000_0003, 32'h0000_0003, "irq status");
    chk({31'h0, irq}, 32'h0000_0000, "irq masked");
    wr(OFS_IRQ_EN, 32'h0000_0002);
    idle(2);
    chk({31'h0, irq}, 32'h0000_0001, "irq raised");
    wr(OFS_IRQ_CLR, 32'h0000_0007);
    idle(2);
    rd(OFS_IRQ_STS);
    chk(q, 32'h0000_0000, "irq cleared");
    chk({31'h0, irq}, 32'h0000_0000, "irq dropped");
    wr(OFS_IRQ_EN, 32'h0000_0000);
    $display("test dual done");
    // sync: selected source clears only the primary half
    wr(OFS_PRI_PRD, 32'h0000_FFFF);
    wr(OFS_SEC_PRD, 32'h0000_FFFF);
    wr(OFS_CTRL_HI, 32'h0000_0001);
    wr(OFS_CTRL_LO, 32'h0000_8000);
    idle(50);
    peer.pulse(1);
    idle(2);
    rd(OFS_PRI_CNT);
    chk({31'h0, q < 32'h8}, 32'h0000_0001, "primary cleared");
    rd(OFS_PRI_CNT);
    chk({31'h0, q > 32'h2}, 32'h0000_0001, "count resumed");
    rd(OFS_SEC_CNT);
    chk({31'h0, q > 32'h28}, 32'h0000_0001, "secondary kept");
    $display("test sync done");
    // 32-bit: wide select set before the counts are written
    wr(OFS_CTRL_LO, 32'h0000_0000);
    wr(OFS_CTRL_LO, 32'h0000_8020);
    wr(OFS_SEC_CNT, 32'h0000_0000);
    wr(OFS_PRI_CNT, 32'h0000_FFF0);
    idle(40);
    rd(OFS_SEC_CNT);
    chk(q, 32'h0000_0001, "carry into secondary");
    $display("test wide done");
    // trigger: held until the source asserts, then cleared by software
    wr(OFS_CTRL_LO, 32'h0000_0000);
    wr(OFS_CTRL_HI, 32'h0000_0082);
    wr(OFS_CTRL_LO, 32'h0000_8000);
    idle(20);
    rd(OFS_PRI_CNT);
    chk(q, 32'h0000_0000, "held before trigger");
    rd(OFS_STAT_LO);
    chk(q, 32'h0000_0000, "not armed");
    peer.pulse(2);
    idle(20);
    rd(OFS_STAT_LO);
    chk(q, 32'h0000_0080, "armed");
    rd(OFS_PRI_CNT);
    chk({31'h0, q > 32'hA}, 32'h0000_0001, "running");
    wr(OFS_STAT_LO, 32'h0000_0020);
    idle(3);
    rd(OFS_STAT_LO);
    chk(q, 32'h0000_0000, "disarmed");
    idle(10);
    rd(OFS_PRI_CNT);
    chk(q, 32'h0000_0000, "held after clear");
    $display("test trigger done");
    // a mode other than the timer code, or capture select, keeps the counter still
    wr(OFS_CTRL_LO, 32'h0000_0000);
    wr(OFS_CTRL_HI, 32'h0000_0000);
    wr(OFS_CTRL_LO, 32'h0000_8001);
    idle(20);
    rd(OFS_PRI_CNT);
    chk(q, 32'h0000_0000, "idle in other mode");
    wr(OFS_CTRL_LO, 32'h0000_8010);
    idle(20);
    rd(OFS_PRI_CNT);
    chk(q, 32'h0000_0000, "idle in capture mode");
    // time base 1 counts only on its own tick enable
    wr(OFS_CTRL_LO, 32'h0000_8100);
    idle(20);
    rd(OFS_PRI_CNT);
    chk(q, 32'h0000_0000, "no time-base tick");
    tb_tick <= 7'h01;
    idle(20);
    rd(OFS_PRI_CNT);
    chk({31'h0, q > 32'hA}, 32'h0000_0001, "time-base ticks");
    $display("test mode done");
    final_report();
  end
endmodule : testbench
`default_nettype wire

// [verilog/ccpgt_cnt_if.sv]
// ccpgt_cnt_if: control and status of one 16-bit counter half
`timescale 1ns/1ps
`default_nettype none
interface ccpgt_cnt_if;
  logic        tick;
  logic        clr;
  logic        load;
  logic [15:0] ld_val;
  logic        use_prd;
  logic [15:0] period;
  logic [15:0] count;
  logic        at_match;
  logic        carry;
  modport ctl (output tick, clr, load, ld_val, use_prd, period,
               input count, at_match, carry);
  modport cnt (input tick, clr, load, ld_val, use_prd, period,
               output count, at_match, carry);
endinterface : ccpgt_cnt_if
`default_nettype wire

// [verilog/ccpgt_counter.sv]
// ccpgt_counter: one 16-bit counter half with period compare
`timescale 1ns/1ps
`default_nettype none
module ccpgt_counter
  import ccpgt_pkg::*;
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // control from the timer core
  ccpgt_cnt_if.cnt  cif
);
  typedef struct packed {
    logic [15:0] count;
  } ccpgt_cnt_st_t;

  ccpgt_cnt_st_t st_q;
  ccpgt_cnt_st_t st_d;

  assign cif.count    = st_q.count;
  assign cif.at_match = cif.tick & cif.use_prd & (st_q.count == cif.period);
  assign cif.carry    = cif.tick & (st_q.count == CNT_ALL1);

  always_comb
  begin
    st_d = st_q;
    // clear outranks a load so a held timer never leaves zero
    if (cif.clr)
      st_d.count = CNT_RST;
    else if (cif.load)
      st_d.count = cif.ld_val;
    else if (cif.at_match)
      st_d.count = CNT_RST;
    else if (cif.tick)
      st_d.count = st_q.count + 16'h0001;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_q <= '{count: 16'h0000};
    else
      st_q <= st_d;
  end

  AST_WRAP_ZERO: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    cif.at_match && !cif.clr && !cif.load |=> cif.count == CNT_RST)
    else $error("counter did not wrap after period match");
endmodule : ccpgt_counter
`default_nettype wire

// [verilog/ccpgt_pkg.sv]
// ccpgt_pkg: constants for the capture/compare unit general purpose timer
package ccpgt_pkg;
  localparam int          CNT_W         = 16;
  localparam int          SRC_W         = 32;
  // register byte offsets
  localparam logic [7:0]  OFS_CTRL_LO   = 8'h00;
  localparam logic [7:0]  OFS_CTRL_HI   = 8'h04;
  localparam logic [7:0]  OFS_STAT_LO   = 8'h08;
  localparam logic [7:0]  OFS_PRI_CNT   = 8'h0C;
  localparam logic [7:0]  OFS_SEC_CNT   = 8'h10;
  localparam logic [7:0]  OFS_PRI_PRD   = 8'h14;
  localparam logic [7:0]  OFS_SEC_PRD   = 8'h18;
  localparam logic [7:0]  OFS_IRQ_STS   = 8'h1C;
  localparam logic [7:0]  OFS_IRQ_CLR   = 8'h20;
  localparam logic [7:0]  OFS_IRQ_EN    = 8'h24;
  // unit_control_low fields
  localparam int          CL_MODE_LSB   = 0;
  localparam int          CL_CAPTURE_COMPARE_SELECT_BIT  = 4;
  localparam int          CL_WIDE_BIT   = 5;
  localparam int          CL_TB_LSB     = 8;
  localparam int          CL_ON_BIT     = 15;
  // unit_control_high fields
  localparam int          CH_SYNC_LSB   = 0;
  localparam int          CH_TRIG_BIT   = 7;
  // unit_status_low fields
  localparam int          ST_TRIGGER_CLEAR_REQUEST_BIT  = 5;
  localparam int          ST_ARMED_BIT  = 7;
  // interrupt status bits
  localparam int          IRQ_N         = 3;
  localparam int          IRQ_PRI_MATCH = 0;
  localparam int          IRQ_CMP_EVT   = 1;
  localparam int          IRQ_TRIG      = 2;
  // codes and reset values
  localparam logic [3:0]  MODE_TIMER    = 4'h0;
  localparam logic [4:0]  SYNC_OFF      = 5'h00;
  localparam logic [2:0]  TB_SYSCLK     = 3'h0;
  localparam logic [15:0] CNT_RST       = 16'h0000;
  localparam logic [15:0] CNT_ALL1      = 16'hFFFF;
endpackage : ccpgt_pkg

// [verilog/ccpgt_sync_sel.sv]
// ccpgt_sync_sel: picks the sync/trigger source and flags its assertion
`timescale 1ns/1ps
`default_nettype none
module ccpgt_sync_sel
  import ccpgt_pkg::*;
(
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // source vector and selection
  input  wire logic [SRC_W-1:0] src,
  input  wire logic [4:0]       sel,
  // one-cycle pulse on assertion of the chosen source
  output logic                  evt
);
  typedef struct packed {
    logic prev;
  } ccpgt_sel_st_t;

  ccpgt_sel_st_t st_q;
  ccpgt_sel_st_t st_d;
  logic          lvl;

  // code zero is off; edge detection keeps a long level from re-firing
  assign lvl = (sel != SYNC_OFF) & src[sel];
  assign evt = lvl & ~st_q.prev;

  always_comb
  begin
    st_d      = st_q;
    st_d.prev = lvl;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_q <= '{prev: 1'b0};
    else
      st_q <= st_d;
  end

  AST_SEL_OFF: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    sel == SYNC_OFF |-> !evt)
    else $error("sync event raised with source off");
endmodule : ccpgt_sync_sel
`default_nettype wire

// [verilog/ccpgt_timer.sv]
// ccpgt_timer: general purpose timer core with APB registers and interrupt
`timescale 1ns/1ps
`default_nettype none
module ccpgt_timer
  import ccpgt_pkg::*;
(
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // apb slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic                  pready,
  output logic                  pslverr,
  output logic [31:0]           prdata,
  // time-base tick enables, index = time_base_select, 0 is sys_clk
  input  wire logic [7:1]       tb_tick,
  // sync/trigger sources from peer units
  input  wire logic [SRC_W-1:0] sync_src,
  // outputs to peers and interrupt controller
  output logic                  sync_out,
  output logic                  compare_event_flag,
  output logic                  irq
);
  typedef struct packed {
    logic              unit_on;
    logic [2:0]        time_base_select;
    logic              capture_compare_select;
    logic              wide_counter_select;
    logic [3:0]        operating_mode_field;
    logic              trigger_operation_select;
    logic [4:0]        sync_select;
    logic [15:0]       primary_period_reg;
    logic [15:0]       secondary_period_reg;
    logic              trigger_armed_status;
    logic [IRQ_N-1:0]  irq_sts;
    logic [IRQ_N-1:0]  irq_en;
    logic [31:0]       rdata;
    logic              sync_out;
    logic              cmp_evt;
  } ccpgt_state_t;

  localparam ccpgt_state_t ST_RST = '0;

  ccpgt_state_t st_q;
  ccpgt_state_t st_d;

  ccpgt_cnt_if  pri_if ();
  ccpgt_cnt_if  sec_if ();

  logic         setup_ph;
  logic         wr_acc;
  logic         addr_ok;
  logic         mode_ok;
  logic         base_tick;
  logic         sync_evt;
  logic         trig_clr;
  logic         hold;
  logic         sync_clr;
  logic         match32;
  logic [7:0]   tick_vec;
  logic [IRQ_N-1:0] irq_set;
  logic [IRQ_N-1:0] irq_clr;

  // submodules
  ccpgt_counter u_pri (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .cif     (pri_if)
  );

  ccpgt_counter u_sec (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .cif     (sec_if)
  );

  ccpgt_sync_sel u_sel (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .src     (sync_src),
    .sel     (st_q.sync_select),
    .evt     (sync_evt)
  );

  // apb decode: read data is captured in setup, so access never waits
  assign setup_ph = psel & ~penable;
  assign wr_acc   = psel & penable & pwrite & addr_ok;
  assign pready   = psel & penable;
  assign pslverr  = psel & penable & ~addr_ok;
  assign prdata   = st_q.rdata;

  always_comb
  begin
    case (paddr)
      OFS_CTRL_LO, OFS_CTRL_HI, OFS_STAT_LO, OFS_PRI_CNT, OFS_SEC_CNT,
      OFS_PRI_PRD, OFS_SEC_PRD, OFS_IRQ_STS, OFS_IRQ_CLR, OFS_IRQ_EN:
        addr_ok = 1'b1;
      default:
        addr_ok = 1'b0;
    endcase
  end

  // mode qualification and time base
  assign mode_ok = st_q.unit_on & ~st_q.capture_compare_select
                 & (st_q.operating_mode_field == MODE_TIMER);
  assign tick_vec  = {tb_tick, 1'b1};
  // trigger mode presumes the sys_clk time base; others still tick here
  assign base_tick = mode_ok & tick_vec[st_q.time_base_select];

  // sync and trigger control
  assign trig_clr = wr_acc & (paddr == OFS_STAT_LO) & pwdata[ST_TRIGGER_CLEAR_REQUEST_BIT];
  // armed timer keeps running; unarmed one is held at zero
  assign hold     = ~mode_ok
                  | (st_q.trigger_operation_select
                     & ~st_q.trigger_armed_status);
  // source 11111 is software's to avoid; hardware treats it like any other
  assign sync_clr = ~st_q.trigger_operation_select & sync_evt;

  // 32-bit period match across both halves
  assign match32  = st_q.wide_counter_select & base_tick & ~hold
                  & (pri_if.count == st_q.primary_period_reg)
                  & (sec_if.count == st_q.secondary_period_reg);

  // primary half
  always_comb
  begin
    pri_if.tick    = base_tick & ~hold;
    pri_if.use_prd = ~st_q.wide_counter_select;
    pri_if.period  = st_q.primary_period_reg;
    pri_if.clr     = hold | sync_clr | trig_clr | match32;
    pri_if.load    = wr_acc & (paddr == OFS_PRI_CNT);
    pri_if.ld_val  = pwdata[15:0];
  end

  // secondary half: free periodic source in dual, upper word in 32-bit
  always_comb
  begin
    if (st_q.wide_counter_select)
    begin
      sec_if.tick = pri_if.carry;
      sec_if.clr  = hold | sync_clr | trig_clr | match32;
    end
    else
    begin
      sec_if.tick = base_tick;
      sec_if.clr  = ~mode_ok;
    end
    sec_if.use_prd = ~st_q.wide_counter_select;
    sec_if.period  = st_q.secondary_period_reg;
    sec_if.load    = wr_acc & (paddr == OFS_SEC_CNT);
    sec_if.ld_val  = pwdata[15:0];
  end

  // interrupt events
  always_comb
  begin
    irq_set                = '0;
    irq_set[IRQ_PRI_MATCH] = pri_if.at_match | match32;
    irq_set[IRQ_CMP_EVT]   = sec_if.at_match | match32;
    irq_set[IRQ_TRIG]      = st_q.trigger_operation_select & mode_ok
                           & sync_evt & ~st_q.trigger_armed_status;
    irq_clr = (wr_acc && paddr == OFS_IRQ_CLR) ? pwdata[IRQ_N-1:0] : '0;
  end

  assign irq                = |(st_q.irq_sts & st_q.irq_en);
  assign sync_out           = st_q.sync_out;
  assign compare_event_flag = st_q.cmp_evt;

  // state update
  always_comb
  begin
    st_d = st_q;
    // register writes
    if (wr_acc)
    begin
      case (paddr)
        OFS_CTRL_LO:
        begin
          st_d.unit_on                = pwdata[CL_ON_BIT];
          st_d.time_base_select       = pwdata[CL_TB_LSB +: 3];
          st_d.capture_compare_select = pwdata[CL_CAPTURE_COMPARE_SELECT_BIT];
          st_d.wide_counter_select    = pwdata[CL_WIDE_BIT];
          st_d.operating_mode_field   = pwdata[CL_MODE_LSB +: 4];
        end
        OFS_CTRL_HI:
        begin
          st_d.trigger_operation_select = pwdata[CH_TRIG_BIT];
          st_d.sync_select              = pwdata[CH_SYNC_LSB +: 5];
        end
        OFS_PRI_PRD:
          st_d.primary_period_reg = pwdata[15:0];
        OFS_SEC_PRD:
          st_d.secondary_period_reg = pwdata[15:0];
        OFS_IRQ_EN:
          st_d.irq_en = pwdata[IRQ_N-1:0];
        default:
          st_d.rdata = st_q.rdata;
      endcase
    end
    // trigger armed status: an arriving trigger wins over a clear request
    if (trig_clr)
      st_d.trigger_armed_status = 1'b0;
    if (irq_set[IRQ_TRIG])
      st_d.trigger_armed_status = 1'b1;
    // sticky interrupt status, set wins over clear
    st_d.irq_sts = (st_q.irq_sts & ~irq_clr) | irq_set;
    // peer outputs: in dual, sync out from the primary side and compare event from the secondary; in 32-bit, both from match32
    st_d.sync_out = pri_if.at_match | match32;
    st_d.cmp_evt  = sec_if.at_match | match32;
    // read data captured in the setup phase
    if (setup_ph && !pwrite)
    begin
      case (paddr)
        OFS_CTRL_LO:
        begin
          st_d.rdata                        = '0;
          st_d.rdata[CL_ON_BIT]             = st_q.unit_on;
          st_d.rdata[CL_TB_LSB +: 3]        = st_q.time_base_select;
          st_d.rdata[CL_CAPTURE_COMPARE_SELECT_BIT]          = st_q.capture_compare_select;
          st_d.rdata[CL_WIDE_BIT]           = st_q.wide_counter_select;
          st_d.rdata[CL_MODE_LSB +: 4]      = st_q.operating_mode_field;
        end
        OFS_CTRL_HI:
        begin
          st_d.rdata                        = '0;
          st_d.rdata[CH_TRIG_BIT]           = st_q.trigger_operation_select;
          st_d.rdata[CH_SYNC_LSB +: 5]      = st_q.sync_select;
        end
        OFS_STAT_LO:
        begin
          st_d.rdata                        = '0;
          st_d.rdata[ST_ARMED_BIT]          = st_q.trigger_armed_status;
        end
        OFS_PRI_CNT:
          st_d.rdata = {16'h0000, pri_if.count};
        OFS_SEC_CNT:
          st_d.rdata = {16'h0000, sec_if.count};
        OFS_PRI_PRD:
          st_d.rdata = {16'h0000, st_q.primary_period_reg};
        OFS_SEC_PRD:
          st_d.rdata = {16'h0000, st_q.secondary_period_reg};
        OFS_IRQ_STS:
          st_d.rdata = {29'h0000000, st_q.irq_sts};
        OFS_IRQ_EN:
          st_d.rdata = {29'h0000000, st_q.irq_en};
        default:
          st_d.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_q <= ST_RST;
    else
      st_q <= st_d;
  end

  // checks
  sequence seq_trig_fire;
    st_q.trigger_operation_select && mode_ok && sync_evt
      && !st_q.trigger_armed_status;
  endsequence

  sequence seq_armed_run;
    st_q.trigger_armed_status && pri_if.tick;
  endsequence

  sequence seq_trig_clear;
    trig_clr && !irq_set[IRQ_TRIG];
  endsequence

  AST_MODE_GATE: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !mode_ok |-> !pri_if.tick && !sec_if.tick && pri_if.clr)
    else $error("timer ran outside timer mode");

  AST_DUAL_SEC_FREE: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !st_q.wide_counter_select && mode_ok && sec_if.tick
      && !sec_if.at_match && !sec_if.load
      |=> sec_if.count == $past(sec_if.count) + 16'h0001)
    else $error("secondary half disturbed in dual mode");

  AST_SYNC_CLEARS: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    mode_ok && !st_q.trigger_operation_select && sync_evt
      |=> pri_if.count == CNT_RST)
    else $error("sync did not clear primary count");

  // a zero period may match on two ticks in a row, so look one back
  AST_CMP_EVENT: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !st_q.wide_counter_select && sec_if.at_match
      |=> compare_event_flag
          ##1 (!compare_event_flag || $past(sec_if.at_match)))
    else $error("compare event flag not one pulse after secondary match");

  AST_CMP_STICKY: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    sec_if.at_match |=> st_q.irq_sts[IRQ_CMP_EVT])
    else $error("compare event did not set its status bit");

  AST_CASCADE: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    st_q.wide_counter_select && pri_if.carry && !sec_if.clr && !sec_if.load
      |=> sec_if.count == $past(sec_if.count) + 16'h0001)
    else $error("secondary did not step on primary overflow");

  AST_WIDE_WRAP: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    match32 && !pri_if.load && !sec_if.load
      |=> pri_if.count == CNT_RST && sec_if.count == CNT_RST)
    else $error("32-bit period match did not clear both halves");

  AST_TRIG_HOLD: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    st_q.trigger_operation_select && !st_q.trigger_armed_status
      |=> pri_if.count == CNT_RST)
    else $error("unarmed trigger timer left zero");

  AST_TRIG_START: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    seq_trig_fire |=> seq_armed_run)
    else $error("trigger did not start the timer");

  AST_ARMED_KEEP: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    st_q.trigger_armed_status && !trig_clr |=> st_q.trigger_armed_status)
    else $error("armed status dropped without a clear request");

  AST_TRIG_CLEAR: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    seq_trig_clear |=> !st_q.trigger_armed_status
      && pri_if.count == CNT_RST)
    else $error("trigger clear did not disarm and zero the timer");

  AST_SYNC_OUT_PRI: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !st_q.wide_counter_select && $rose(sync_out)
      |-> $past(pri_if.at_match))
    else $error("sync out not caused by primary match");
endmodule : ccpgt_timer
`default_nettype wire
